//--- fbs_defs.vh
// Constants for the field-bus status lamp and node configuration block
`ifndef FBS_DEFS_VH
`define FBS_DEFS_VH
// Bus variant select
`define FBS_VAR_CAN 1'b0
`define FBS_VAR_DP 1'b1
// Speed codes on the CAN-based variant
`define FBS_SPD_AUTO 2'h0
`define FBS_SPD_125K 2'h1
`define FBS_SPD_250K 2'h2
`define FBS_SPD_500K 2'h3
`define FBS_SPD_DEFAULT 2'h0
// Node address limits
`define FBS_ADDR_MIN 8'h01
`define FBS_CAN_ADDR_MAX 8'hFF
`define FBS_DP_ADDR_MAX 8'h7D
`define FBS_ADDR_DEFAULT 8'h01
// Lamp colour codes {red, green}
`define FBS_LAMP_OFF 2'h0
`define FBS_LAMP_GREEN 2'h1
`define FBS_LAMP_RED 2'h2
// Lamp pattern codes
`define FBS_PAT_OFF 3'h0
`define FBS_PAT_GRN 3'h1
`define FBS_PAT_GRN_BLK 3'h2
`define FBS_PAT_RED 3'h3
`define FBS_PAT_RED_BLK 3'h4
`define FBS_PAT_RED_1 3'h5
`define FBS_PAT_RED_2 3'h6
// Timing: blink half-period of 250 ms at the 40 MHz core clock
`define FBS_HALF_CYC 32'h0098_9680
// Frame steps on which a counted red blink is lit
`define FBS_STEP_BLINK1 4'h0
`define FBS_STEP_BLINK2 4'h2
// Number of half-periods in one counted-blink frame (two blinks then a long pause)
`define FBS_FRAME_STEPS 4'h8
`define FBS_FRAME_LAST 4'h7
`endif

//--- fbs_lamp_gen.v
// Bicolour lamp pattern generator for one lamp
`timescale 1ns/100ps
`include "fbs_defs.vh"
module fbs_lamp_gen (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Shared timing
    input wire phase,
    input wire [3:0] step,
    // Requested pattern
    input wire [2:0] pattern,
    // Lamp drive {red, green}
    output reg [1:0] lamp_ff
);
    reg [1:0] nxt_lamp;

    // Map pattern and timing to colour; counted blinks light on steps 0 and 2 only
    always @* begin
        case (pattern)
            `FBS_PAT_GRN: nxt_lamp = `FBS_LAMP_GREEN;
            `FBS_PAT_GRN_BLK: nxt_lamp = phase ? `FBS_LAMP_GREEN : `FBS_LAMP_OFF;
            `FBS_PAT_RED: nxt_lamp = `FBS_LAMP_RED;
            `FBS_PAT_RED_BLK: nxt_lamp = phase ? `FBS_LAMP_RED : `FBS_LAMP_OFF;
            // One blink, then a long pause
            `FBS_PAT_RED_1: nxt_lamp = (step == `FBS_STEP_BLINK1) ? `FBS_LAMP_RED : `FBS_LAMP_OFF;
            // Two blinks, then a long pause
            `FBS_PAT_RED_2: begin
                if (step == `FBS_STEP_BLINK1 || step == `FBS_STEP_BLINK2) begin
                    nxt_lamp = `FBS_LAMP_RED;
                end else begin
                    nxt_lamp = `FBS_LAMP_OFF;
                end
            end
            default: nxt_lamp = `FBS_LAMP_OFF;
        endcase
    end

    // Registered lamp output
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lamp_ff <= `FBS_LAMP_OFF;
        end else begin
            lamp_ff <= nxt_lamp;
        end
    end
endmodule // fbs_lamp_gen

//--- fbs_status_cfg.v
// Field-bus slave status lamps and node configuration
//
// Operation
// - CAN speed auto or 125/250/500k, default auto
// - CAN node address accepted only 1 to 255
// - Duplicate address flags error, blocks joining
// - Module lamp: off, run, size, fault, warn
// - Network lamp: off, connected, idle, fatal, timeout
// - All nodes share one communication speed
// - DP variant follows bus rate automatically
// - DP status lamp: off, init, diag, exception
// - DP mode lamp: offline, exchange, clear, counted red
// - DP node address accepted only 1 to 125
// - CAN variant is group 2 I/O slave only
`timescale 1ns/100ps
`include "fbs_defs.vh"
module fbs_status_cfg #(
    parameter HALF_CYC = `FBS_HALF_CYC
) (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Variant select
    input wire variant,
    // Configuration write
    input wire cfg_wr,
    input wire [7:0] cfg_addr,
    input wire [1:0] cfg_speed,
    // Detected conditions from the protocol side
    input wire dup_addr_det,
    input wire dup_check_done,
    input wire board_ok,
    input wire hw_fault,
    input wire size_err,
    input wire minor_warn,
    input wire bus_power,
    input wire connected,
    input wire net_fatal,
    input wire net_timeout,
    input wire init_done,
    input wire diag_pending,
    input wire if_exception,
    input wire online,
    input wire dx_active,
    input wire clear_mode,
    input wire param_err,
    input wire config_err,
    input wire rate_locked,
    // Configuration and status
    output reg [7:0] node_addr_ff,
    output reg [1:0] speed_ff,
    output reg auto_baud_ff,
    output reg cfg_reject_ff,
    output reg dup_addr_ff,
    output reg join_en_ff,
    output reg io_only_ff,
    // Lamps {red, green}
    output wire [1:0] lamp1_ff,
    output wire [1:0] lamp2_ff
);
    ////////////////////////////////////////////////////////////////////////////////
    // Blink timebase
    // One timebase feeds both lamps so that their blinks stay in step; the
    // counted red codes ride on the frame step, plain blinks on the phase bit
    localparam LAMPS = 2; // Lamps driven by this block
    reg [31:0] tick_cnt_ff; // Half-period counter
    reg phase_ff; // Plain blink phase
    reg [3:0] step_ff; // Counted-blink frame step
    reg [2:0] pat1; // Pattern for lamp one
    reg [2:0] pat2; // Pattern for lamp two
    wire addr_ok; // Address inside variant range
    wire [3*LAMPS-1:0] pat_bus; // Patterns of all lamps, lamp one lowest
    wire [2*LAMPS-1:0] lamp_bus; // Drives of all lamps, lamp one lowest

    // Free-running half-period tick from the system clock
    // The counter wraps after HALF_CYC cycles; each wrap flips the phase and
    // moves the counted-blink frame on by one step, wrapping after the last
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tick_cnt_ff <= 32'h0;
            phase_ff <= 1'b0;
            step_ff <= 4'h0;
        end else if (tick_cnt_ff == HALF_CYC - 32'h1) begin
            tick_cnt_ff <= 32'h0;
            phase_ff <= ~phase_ff;
            step_ff <= (step_ff == `FBS_FRAME_LAST) ? 4'h0 : step_ff + 4'h1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration

    // Range check depends on variant
    // Address 0 is never a valid node on either variant; the upper limit is
    // the variant's own, so a write is judged by the variant selected now
    assign addr_ok = (cfg_addr >= `FBS_ADDR_MIN) &&
        ((variant == `FBS_VAR_DP) ? (cfg_addr <= `FBS_DP_ADDR_MAX)
                                  : (cfg_addr <= `FBS_CAN_ADDR_MAX));

    // Store settings; out-of-range addresses are refused and flagged
    // The speed code is taken on every write on the CAN variant, even when the
    // address is refused; only the address is guarded by the range check.
    // A refused write leaves the old address in force and raises the reject
    // flag until the next write.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            node_addr_ff <= `FBS_ADDR_DEFAULT;
            speed_ff <= `FBS_SPD_DEFAULT;
            cfg_reject_ff <= 1'b0;
        end else if (cfg_wr) begin
            // Reject flag reports the latest write only
            cfg_reject_ff <= ~addr_ok;
            if (addr_ok) begin
                node_addr_ff <= cfg_addr;
            end
            // Speed is fixed by the master's rate; DP ignores it
            if (variant == `FBS_VAR_CAN) begin
                speed_ff <= cfg_speed;
            end
        end
    end

    // Auto detection: always on DP, when selected on CAN
    // The flag follows the stored speed, so it settles one cycle after speed_ff, two cycles after the write
    // The I/O-only flag is fixed: explicit messaging is never offered
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            auto_baud_ff <= 1'b1;
            io_only_ff <= 1'b1;
        end else begin
            auto_baud_ff <= (variant == `FBS_VAR_DP) || (speed_ff == `FBS_SPD_AUTO);
            io_only_ff <= 1'b1; // Group 2 slave, I/O only, no explicit messages
        end
    end

    // Duplicate flag sticks until a new address is written; set wins over clear
    // A detection in the same cycle as a valid write keeps the flag set, so a
    // node cannot clear a live clash by rewriting its address.
    // Joining waits for the duplicate check, and on DP also for rate lock.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dup_addr_ff <= 1'b0;
            join_en_ff <= 1'b0;
        end else begin
            if (dup_addr_det) begin
                dup_addr_ff <= 1'b1;
            end else if (cfg_wr && addr_ok) begin
                dup_addr_ff <= 1'b0;
            end
            // Join only once the check is over and no clash is known
            join_en_ff <= dup_check_done && !dup_addr_det && !dup_addr_ff &&
                (variant == `FBS_VAR_CAN ? 1'b1 : rate_locked);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Lamp pattern selection, worst condition first
    // CAN variant: lamp one is the module lamp, lamp two the network lamp.
    // DP variant: lamp one is the status lamp, lamp two the operation-mode lamp.
    // Each chain tests the most serious condition first, so a fault always
    // shows over a lesser state.
    always @* begin
        pat1 = `FBS_PAT_OFF;
        pat2 = `FBS_PAT_OFF;
        if (variant == `FBS_VAR_CAN) begin
            // Missing board first, then hardware fault, warning and size error
            // Module lamp
            if (!board_ok) pat1 = `FBS_PAT_OFF;
            else if (hw_fault) pat1 = `FBS_PAT_RED;
            else if (minor_warn) pat1 = `FBS_PAT_RED_BLK;
            else if (size_err) pat1 = `FBS_PAT_GRN_BLK;
            else pat1 = `FBS_PAT_GRN;
            // No bus power first, then fatal or clash, pending check, timeout
            // Network lamp
            if (!bus_power) pat2 = `FBS_PAT_OFF;
            else if (net_fatal || dup_addr_ff) pat2 = `FBS_PAT_RED;
            else if (!dup_check_done) pat2 = `FBS_PAT_OFF;
            else if (net_timeout) pat2 = `FBS_PAT_RED_BLK;
            else if (connected) pat2 = `FBS_PAT_GRN;
            else pat2 = `FBS_PAT_GRN_BLK;
        end else begin
            // An exception shows even before initialisation has finished
            // Status lamp
            if (if_exception) pat1 = `FBS_PAT_RED;
            else if (!init_done) pat1 = `FBS_PAT_OFF;
            else if (diag_pending) pat1 = `FBS_PAT_GRN_BLK;
            else pat1 = `FBS_PAT_GRN;
            // Counted red codes first, then offline, clear and data exchange
            // Operation-mode lamp
            if (config_err) pat2 = `FBS_PAT_RED_2;
            else if (param_err) pat2 = `FBS_PAT_RED_1;
            else if (!online) pat2 = `FBS_PAT_OFF;
            else if (clear_mode) pat2 = `FBS_PAT_GRN_BLK;
            else if (dx_active) pat2 = `FBS_PAT_GRN;
            else pat2 = `FBS_PAT_GRN_BLK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Lamp drivers
    // Patterns are packed so that one loop builds every lamp driver
    assign pat_bus = {pat2, pat1};

    // One pattern generator per lamp, all on the shared timebase
    genvar gi;
    generate
        for (gi = 0; gi < LAMPS; gi = gi + 1) begin : g_lamp
            fbs_lamp_gen u_lamp (
                .core_clk(core_clk),
                .rst(rst),
                .phase(phase_ff),
                .step(step_ff),
                .pattern(pat_bus[gi*3 +: 3]),
                .lamp_ff(lamp_bus[gi*2 +: 2])
            );
        end
    endgenerate

    // Each lamp output is the flop inside its generator
    // Lamp one carries the module or status lamp, lamp two the other
    assign lamp1_ff = lamp_bus[1:0];
    assign lamp2_ff = lamp_bus[3:2];
endmodule // fbs_status_cfg

//--- fbs_status_cfg_assertions.sv
// Port checks for the status and configuration block
`timescale 1ns/100ps
module fbs_checker (
    // Clock and reset
    input logic core_clk,
    input logic rst,
    // Configuration side
    input logic variant,
    input logic cfg_wr,
    input logic [7:0] cfg_addr,
    input logic [1:0] cfg_speed,
    input logic dup_addr_det,
    // Outputs under check
    input logic [7:0] node_addr_ff,
    input logic [1:0] speed_ff,
    input logic auto_baud_ff,
    input logic cfg_reject_ff,
    input logic dup_addr_ff,
    input logic join_en_ff
);
    // Address inside the range of the active variant
    wire good = cfg_addr != 8'h00 && (!variant || cfg_addr <= 8'h7D);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////
    property p_take;
        cfg_wr && good |=> node_addr_ff == $past(cfg_addr) && !cfg_reject_ff; endproperty
    a_take: assert property (p_take) else $error("address not taken");
    property p_refuse;
        cfg_wr && !good |=> cfg_reject_ff && $stable(node_addr_ff); endproperty
    a_refuse: assert property (p_refuse) else $error("bad address kept");
    property p_hold;
        !cfg_wr |=> $stable(node_addr_ff) && $stable(cfg_reject_ff); endproperty
    a_hold: assert property (p_hold) else $error("setting moved");
    property p_speed;
        cfg_wr && good && !variant |=> speed_ff == $past(cfg_speed); endproperty
    a_speed: assert property (p_speed) else $error("speed not taken");
    property p_auto;
        cfg_wr && good && !variant && cfg_speed == 2'h0 ##1 !variant |=> auto_baud_ff; endproperty
    a_auto: assert property (p_auto) else $error("auto rate off");
    property p_dp_auto;
        variant [*3] |-> auto_baud_ff; endproperty
    a_dp_auto: assert property (p_dp_auto) else $error("dp rate not auto");
    property p_dup;
        dup_addr_det |=> dup_addr_ff; endproperty
    a_dup: assert property (p_dup) else $error("duplicate not flagged");
    property p_no_join;
        dup_addr_det |=> ##1 !join_en_ff; endproperty
    a_no_join: assert property (p_no_join) else $error("joined with duplicate");
endmodule // fbs_checker
bind fbs_status_cfg fbs_checker fbs_checker_inst (.core_clk, .rst, .variant, .cfg_wr, .cfg_addr,
    .cfg_speed, .dup_addr_det, .node_addr_ff, .speed_ff, .auto_baud_ff, .cfg_reject_ff,
    .dup_addr_ff, .join_en_ff);

//--- fbs_master_model.sv
// Field-bus master model: owns one address, ends its check, follows rate
`timescale 1ns/100ps
module fbs_master_model #(
    parameter logic [7:0] TAKEN = 8'h0A
) (
    // Clock and reset
    input logic core_clk,
    input logic rst,
    // Slave state
    input logic variant,
    input logic [7:0] node_addr_ff,
    // Bus conditions
    output logic dup_addr_det,
    output logic dup_check_done,
    output logic rate_locked
);
    // Another node already holds TAKEN
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {dup_addr_det, dup_check_done, rate_locked} <= 3'h0;
        end else begin
            dup_addr_det <= node_addr_ff == TAKEN;
            dup_check_done <= 1'h1;
            rate_locked <= variant;
        end
    end
endmodule // fbs_master_model

//--- test_fieldbus_status_and_node_config.sv
// Bench for the status lamps and node configuration block
`timescale 1ns/100ps
module test_fieldbus_status_and_node_config;
    localparam int HC = 4; // Short blink half-period
    logic core_clk = 0, rst = 1, variant = 0, cfg_wr = 0;
    logic [7:0] cfg_addr = 0;
    logic [1:0] cfg_speed = 0;
    logic [15:0] cf = 0; // Condition flags
    wire dup_addr_det, dup_check_done, rate_locked, auto_baud_ff, cfg_reject_ff;
    wire dup_addr_ff, join_en_ff, io_only_ff;
    wire [7:0] node_addr_ff;
    wire [1:0] speed_ff, lamp1_ff, lamp2_ff;
    int miscompares, num_checks, cycles, ma = 1, ms; // Counts and model state
    int q[$] = '{0, 1, 255, 125, 126, 10};
    // Lamp cases {variant, flags, lamp, colour, lit cycles in 64}
    bit [35:0] lt[19] = '{36'h000001040, 36'h000011140, 36'h000051120, 36'h000091220,
        36'h000031240, 36'h000012040, 36'h000112120, 36'h000312140, 36'h000B12220,
        36'h000712240, 36'h100001040, 36'h101001140, 36'h103001120, 36'h105001240,
        36'h100002040, 36'h118002140, 36'h128002120, 36'h148002208, 36'h1C8002210};
    fbs_status_cfg #(.HALF_CYC(HC)) fbs_status_cfg_inst (.core_clk, .rst, .variant, .cfg_wr,
        .cfg_addr, .cfg_speed, .dup_addr_det, .dup_check_done, .board_ok(cf[0]),
        .hw_fault(cf[1]), .size_err(cf[2]), .minor_warn(cf[3]), .bus_power(cf[4]),
        .connected(cf[5]), .net_fatal(cf[6]), .net_timeout(cf[7]), .init_done(cf[8]),
        .diag_pending(cf[9]), .if_exception(cf[10]), .online(cf[11]), .dx_active(cf[12]),
        .clear_mode(cf[13]), .param_err(cf[14]), .config_err(cf[15]), .rate_locked,
        .node_addr_ff, .speed_ff, .auto_baud_ff, .cfg_reject_ff, .dup_addr_ff, .join_en_ff,
        .io_only_ff, .lamp1_ff, .lamp2_ff);
    fbs_master_model fbs_master_model_inst (.core_clk, .rst, .variant, .node_addr_ff,
        .dup_addr_det, .dup_check_done, .rate_locked);
    initial forever #12.5 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////
    task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", w, e, g);
        end
    endtask
    // Write, then update the model and compare
    task automatic wr(input logic [7:0] a, input logic [1:0] s);
        bit ok;
        @(posedge core_clk);
        ok = a != 0 && (!variant || a <= 8'h7D);
        cfg_wr <= 1'h1;
        cfg_addr <= a;
        cfg_speed <= s;
        @(posedge core_clk);
        cfg_wr <= 1'h0;
        @(posedge core_clk);
        #1;
        if (ok) ma = a;
        if (!variant) ms = s; // CAN takes the speed even with a refused address
        chk("addr", ma[7:0], node_addr_ff);
        chk("reject", !ok, cfg_reject_ff);
        chk("speed", ms[1:0], speed_ff);
        chk("auto", variant || ms == 0, auto_baud_ff);
    endtask
    // Count cycles over two blink frames that a lamp shows one colour
    task automatic lamp(input bit [35:0] e);
        int cnt;
        cnt = 0;
        @(posedge core_clk);
        variant <= e[32];
        cf <= e[31:16];
        for (int k = 0; k < 16 * HC + 2; k++) begin
            @(posedge core_clk);
            #1;
            if (k > 1) cnt += ((e[12] ? lamp1_ff : lamp2_ff) === e[9:8]);
        end
        chk("lamp", e[7:0], cnt[7:0]);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial begin
        void'($urandom(388));
        repeat (2) @(posedge core_clk);
        rst <= 1'h0;
        @(posedge core_clk);
        #1;
        chk("addr", 1, node_addr_ff);
        chk("auto", 1, auto_baud_ff);
        chk("io only", 1, io_only_ff);
        $display("reset test done");
        repeat (3) q.push_back($urandom % 256);
        for (int v = 0; v < 2; v++) begin
            @(posedge core_clk);
            variant <= v[0];
            foreach (q[i]) wr(q[i][7:0], i[1:0]);
        end
        $display("config test done");
        @(posedge core_clk);
        variant <= 1'h0;
        wr(1, 0);
        wr(1, 0);
        foreach (lt[i]) lamp(lt[i]);
        $display("lamp test done");
        wr(8'h0A, 0);
        lamp(36'h000112240);
        chk("dup", 1, dup_addr_ff);
        chk("join", 0, join_en_ff);
        wr(8'h0B, 0);
        wr(8'h0B, 0);
        chk("dup", 0, dup_addr_ff);
        chk("join", 1, join_en_ff);
        // Same clash on the DP variant, where joining also waits for rate lock
        @(posedge core_clk);
        variant <= 1'h1;
        wr(8'h0A, 0);
        repeat (2) @(posedge core_clk);
        #1;
        chk("dup", 1, dup_addr_ff);
        chk("join", 0, join_en_ff);
        wr(8'h0B, 0);
        wr(8'h0B, 0);
        chk("dup", 0, dup_addr_ff);
        chk("join", 1, join_en_ff);
        $display("duplicate test done");
        tally_and_finish();
    end
endmodule // test_fieldbus_status_and_node_config
